// ==== bes_pkg.sv ====
// Purpose: Shared constants and types for the receive-side bit error tester status block.
// Assumes: A 16-bit register port with even byte addresses.
// Notes:   All offsets, field positions and counts live here.
package bes_pkg;

   // ----------------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------------
   localparam logic [7:0] BES_BIT_COUNT_LOW_OFS       = 8'h78;
   localparam logic [7:0] BES_BIT_COUNT_HIGH_OFS      = 8'h7A;
   localparam logic [7:0] BES_STATUS_ERR_LOW_OFS      = 8'h7C;
   localparam logic [7:0] BES_ERR_HIGH_OFS            = 8'h7E;

   // ----------------------------------------------------------------------
   // Status field positions and reset values
   // ----------------------------------------------------------------------
   localparam int         BES_SYNC_BIT                = 0;
   localparam int         BES_ERR_OVF_BIT             = 1;
   localparam int         BES_BIT_OVF_BIT             = 2;
   localparam int         BES_ERR_SEEN_BIT            = 3;
   localparam int         BES_SYNC_LOSS_BIT           = 4;
   localparam int         BES_ZEROS_BIT               = 5;
   localparam int         BES_ONES_BIT                = 6;
   localparam int         BES_ERR_LOW_LSB             = 8;
   localparam logic [15:0] BES_READ_IDLE              = 16'h0000;

   // ----------------------------------------------------------------------
   // Counts
   // ----------------------------------------------------------------------
   localparam int         BES_ERR_COUNT_WIDTH         = 24;
   localparam int         BES_BIT_COUNT_WIDTH         = 32;
   localparam logic [5:0] BES_SYNC_MATCH_LAST         = 6'd31;
   localparam logic [5:0] BES_WINDOW_LAST             = 6'd63;
   localparam logic [2:0] BES_WINDOW_ERR_LAST         = 3'd5;
   localparam logic [4:0] BES_RUN_ALARM_COUNT         = 5'd31;
   localparam int         BES_REF_LEN                 = 15;
   localparam int         BES_REF_TAP_A               = 14;
   localparam int         BES_REF_TAP_B               = 13;

   // ----------------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------------
   typedef enum logic {BES_SEARCH, BES_LOCKED} bes_state_t;

   typedef struct packed {
      logic overflow_irq_enable;
      logic error_irq_enable;
      logic sync_change_irq_enable;
      logic counter_clear_toggle;
   } bes_ctrl_t;

   typedef struct packed {
      logic       rd;
      logic [7:0] addr;
   } bes_cpu_req_t;

   typedef struct packed {
      logic all_ones_alarm;
      logic all_zeros_alarm;
      logic sync_loss_alarm;
      logic bit_error_seen_flag;
      logic bit_count_overflow_flag;
      logic error_count_overflow_flag;
   } bes_flags_t;

endpackage

// ==== bes_sat_counter.sv ====
// Purpose: Saturating up counter with synchronous clear.
// Assumes: Clear and increment come from logic on the same clock.
// Notes:   The saturate pulse fires only on the step into the maximum.
module bes_sat_counter
   import bes_pkg::*;
#(
   parameter int WIDTH = 24
) (
   input  wire logic             clk_in,
   input  wire logic             reset_in,
   input  wire logic             clear_in,
   input  wire logic             inc_in,
   output logic [WIDTH-1:0]      count_out,
   output logic                  saturate_out
);

   if (WIDTH < 2) begin : g_width_check
      $error("bes_sat_counter needs WIDTH of at least 2");
   end

   localparam logic [WIDTH-1:0] MAX_COUNT = '1;

   logic [WIDTH-1:0] count_reg;
   logic [WIDTH-1:0] count_next;
   wire              at_max = (count_reg == MAX_COUNT);
   wire              step   = inc_in && !at_max && !clear_in;

   // Clear has priority; the count holds at the top instead of wrapping.
   assign count_next   = clear_in ? '0 : (step ? count_reg + 1'b1 : count_reg); // R17
   assign saturate_out = step && (count_reg == MAX_COUNT - 1'b1);
   assign count_out    = count_reg;

   always_ff @(posedge clk_in) begin
      if (reset_in) count_reg <= '0;
      else          count_reg <= count_next;
   end

   property p_count_step;
      @(posedge clk_in) disable iff (reset_in)
      (inc_in && !clear_in && !at_max) |=> (count_reg == $past(count_reg) + 1'b1);
   endproperty
   a_count_step: assert property (p_count_step) else $error("count did not step by one"); // R14

   property p_count_hold_max;
      @(posedge clk_in) disable iff (reset_in)
      (at_max && !clear_in) |=> at_max;
   endproperty
   a_count_hold_max: assert property (p_count_hold_max) else $error("count left its maximum"); // R17

   property p_count_clear;
      @(posedge clk_in) disable iff (reset_in)
      clear_in |=> (count_reg == '0);
   endproperty
   a_count_clear: assert property (p_count_clear) else $error("count not cleared"); // R16

endmodule // bes_sat_counter

// ==== bes_rx_status.sv ====
// Purpose: Receive-side bit error tester: sync search, error and bit counting, status flags.
// Assumes: Received clock and data arrive as pins and are sampled on clk_in.
// Notes:   Control bits and the master mask come in as plain inputs.
//
// Notes on behaviour
// R1 - Sync rises after 32 matching bits in row.
// R2 - Sync drops at six errors within 64 bits.
// R3 - Error count saturation latches overflow, clear on read.
// R4 - Bit count saturation latches overflow, clear on read.
// R5 - Overflow flags raise interrupt when enabled and unmasked.
// R6 - Errors seen while synchronized latch error flag.
// R7 - Error flag raises interrupt when enabled and unmasked.
// R8 - Searching latches loss alarm, held until read.
// R9 - Sync changes raise interrupt when enabled and unmasked.
// R10 - 31 zeros latch alarm; clears after a one.
// R11 - 31 ones latch alarm; clears after a zero.
// R12 - Reading status register clears all latched flags.
// R13 - Error count bytes placed across both registers.
// R14 - Error counter counts each errored bit.
// R15 - Error counting starts at first sync, never stops.
// R16 - Toggling the clear control zeroes both counters.
// R17 - Counters saturate at maximum, never wrap.
// R18 - Host clears after sync and at interval end.
// R19 - 32-bit bit counter counts every received bit.
// R20 - Errors are mismatches against regenerated reference pattern.
module bes_rx_status
   import bes_pkg::*;
(
   input  wire logic             clk_in,
   input  wire logic             reset_in,
   input  wire logic             rx_clock_in,
   input  wire logic             rx_data_in,
   input  wire bes_ctrl_t        ctrl_in,
   input  wire logic             master_status_irq_mask_in,
   input  wire bes_cpu_req_t     cpu_req_in,
   output logic [15:0]           cpu_rdata_out,
   output logic                  cpu_rvalid_out,
   output logic                  irq_out,
   output logic                  sync_out
);

   // ----------------------------------------------------------------------
   // Pin sampling
   // ----------------------------------------------------------------------
   logic              clk_meta_reg;
   logic              clk_sync_reg;
   logic              clk_prev_reg;
   logic              data_meta_reg;
   logic              data_sync_reg;

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         clk_meta_reg  <= 1'b0;
         clk_sync_reg  <= 1'b0;
         clk_prev_reg  <= 1'b0;
         data_meta_reg <= 1'b0;
         data_sync_reg <= 1'b0;
      end else begin
         clk_meta_reg  <= rx_clock_in;
         clk_sync_reg  <= clk_meta_reg;
         clk_prev_reg  <= clk_sync_reg;
         data_meta_reg <= rx_data_in;
         data_sync_reg <= data_meta_reg;
      end
   end

   // Data is taken on the rising edge of the received clock; both pins see the
   // same two-stage delay, so the sampling relation is kept.
   wire               bit_stb = clk_sync_reg && !clk_prev_reg;
   wire               rx_bit  = data_sync_reg;

   // ----------------------------------------------------------------------
   // Reference pattern and synchroniser
   // ----------------------------------------------------------------------
   bes_state_t        state_reg;
   bes_state_t        state_next;
   logic [BES_REF_LEN-1:0] ref_reg;
   logic [BES_REF_LEN-1:0] ref_next;
   logic [5:0]        match_cnt_reg;
   logic [5:0]        match_cnt_next;
   logic [5:0]        win_cnt_reg;
   logic [5:0]        win_cnt_next;
   logic [2:0]        win_err_reg;
   logic [2:0]        win_err_next;

   wire               locked   = (state_reg == BES_LOCKED);
   wire               ref_bit  = ref_reg[BES_REF_TAP_A] ^ ref_reg[BES_REF_TAP_B];
   wire               mismatch = (rx_bit != ref_bit); // R20
   wire               bit_err  = bit_stb && locked && mismatch; // R6
   wire               win_end  = (win_cnt_reg == BES_WINDOW_LAST);
   wire               err_trip = bit_err && (win_err_reg == BES_WINDOW_ERR_LAST);
   wire               run_done = bit_stb && !mismatch && (match_cnt_reg == BES_SYNC_MATCH_LAST);

   // While searching the reference is seeded from the line, so a clean stream
   // predicts itself; once locked it runs free so line errors do not propagate.
   assign ref_next = !bit_stb ? ref_reg :
                     locked   ? {ref_reg[BES_REF_LEN-2:0], ref_bit} :
                                {ref_reg[BES_REF_LEN-2:0], rx_bit};

   assign match_cnt_next = (!bit_stb || locked) ? (locked ? 6'd0 : match_cnt_reg) :
                           (mismatch ? 6'd0 : match_cnt_reg + 6'd1); // R1

   // The 64-bit error window is a block window, restarted at lock and at each end.
   assign win_cnt_next = !locked ? 6'd0 : (bit_stb ? win_cnt_reg + 6'd1 : win_cnt_reg);
   assign win_err_next = !locked                 ? 3'd0 :
                         (bit_stb && win_end)    ? 3'd0 :
                         bit_err                 ? win_err_reg + 3'd1 :
                                                   win_err_reg; // R2

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         BES_SEARCH: if (run_done) state_next = BES_LOCKED; // R1
         BES_LOCKED: if (err_trip) state_next = BES_SEARCH; // R2
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         state_reg     <= BES_SEARCH;
         ref_reg       <= '0;
         match_cnt_reg <= 6'd0;
         win_cnt_reg   <= 6'd0;
         win_err_reg   <= 3'd0;
      end else begin
         state_reg     <= state_next;
         ref_reg       <= ref_next;
         match_cnt_reg <= match_cnt_next;
         win_cnt_reg   <= win_cnt_next;
         win_err_reg   <= win_err_next;
      end
   end

   assign sync_out = locked;

   // ----------------------------------------------------------------------
   // Counters
   // ----------------------------------------------------------------------
   logic              clear_prev_reg;
   logic              armed_reg;
   logic [BES_ERR_COUNT_WIDTH-1:0] err_count;
   logic [BES_BIT_COUNT_WIDTH-1:0] bit_count;
   logic              err_sat;
   logic              bit_sat;

   wire               count_clear = (ctrl_in.counter_clear_toggle != clear_prev_reg); // R16
   // Once armed, mismatches keep counting through a loss of sync.
   wire               err_inc     = bit_stb && mismatch && armed_reg; // R14 R15

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         clear_prev_reg <= 1'b0;
         armed_reg      <= 1'b0;
      end else begin
         clear_prev_reg <= ctrl_in.counter_clear_toggle;
         if (locked) armed_reg <= 1'b1; // R15
      end
   end

   bes_sat_counter #(
      .WIDTH        (BES_ERR_COUNT_WIDTH)
   ) u_err_counter (
      .clk_in       (clk_in),
      .reset_in     (reset_in),
      .clear_in     (count_clear),
      .inc_in       (err_inc),
      .count_out    (err_count),
      .saturate_out (err_sat)
   );

   bes_sat_counter #(
      .WIDTH        (BES_BIT_COUNT_WIDTH)
   ) u_bit_counter (
      .clk_in       (clk_in),
      .reset_in     (reset_in),
      .clear_in     (count_clear),
      .inc_in       (bit_stb), // R19
      .count_out    (bit_count),
      .saturate_out (bit_sat)
   );

   // ----------------------------------------------------------------------
   // Run detectors for all-zeros and all-ones
   // ----------------------------------------------------------------------
   logic [4:0]        zero_run_reg;
   logic [4:0]        one_run_reg;

   wire               zero_full = (zero_run_reg == BES_RUN_ALARM_COUNT);
   wire               one_full  = (one_run_reg == BES_RUN_ALARM_COUNT);

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         zero_run_reg <= 5'd0;
         one_run_reg  <= 5'd0;
      end else if (bit_stb) begin
         zero_run_reg <= rx_bit ? 5'd0 : (zero_full ? zero_run_reg : zero_run_reg + 5'd1);
         one_run_reg  <= !rx_bit ? 5'd0 : (one_full ? one_run_reg : one_run_reg + 5'd1);
      end
   end

   // ----------------------------------------------------------------------
   // Latched flags and interrupt
   // ----------------------------------------------------------------------
   bes_flags_t        flags_reg;
   bes_flags_t        flags_set;
   bes_flags_t        flags_next;
   logic              sync_chg_reg;
   logic              sync_chg_next;

   wire               status_read = cpu_req_in.rd && (cpu_req_in.addr == BES_STATUS_ERR_LOW_OFS);
   wire               sync_change = (state_next != state_reg);

   // Alarms are level-set while their cause persists, so a read only clears
   // them once the cause has gone; events are single pulses.
   assign flags_set.error_count_overflow_flag = err_sat; // R3
   assign flags_set.bit_count_overflow_flag   = bit_sat; // R4
   assign flags_set.bit_error_seen_flag       = bit_err; // R6
   assign flags_set.sync_loss_alarm           = !locked; // R8
   assign flags_set.all_zeros_alarm           = zero_full; // R10
   assign flags_set.all_ones_alarm            = one_full; // R11

   // Set wins over the clear so an event in the read cycle is kept.
   assign flags_next    = (status_read ? '0 : flags_reg) | flags_set; // R12
   assign sync_chg_next = (status_read ? 1'b0 : sync_chg_reg) | sync_change; // R9

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         flags_reg    <= '0;
         sync_chg_reg <= 1'b0;
      end else begin
         flags_reg    <= flags_next;
         sync_chg_reg <= sync_chg_next;
      end
   end

   wire               irq_of   = ctrl_in.overflow_irq_enable &&
                                 (flags_reg.error_count_overflow_flag ||
                                  flags_reg.bit_count_overflow_flag); // R5
   wire               irq_err  = ctrl_in.error_irq_enable && flags_reg.bit_error_seen_flag; // R7
   wire               irq_sync = ctrl_in.sync_change_irq_enable && sync_chg_reg; // R9

   assign irq_out = master_status_irq_mask_in && (irq_of || irq_err || irq_sync);

   // ----------------------------------------------------------------------
   // Register read port
   // ----------------------------------------------------------------------
   logic [15:0]       rdata_reg;
   logic              rvalid_reg;
   logic [15:0]       status_word;
   logic [15:0]       read_mux;

   always_comb begin
      status_word                   = '0;
      status_word[BES_SYNC_BIT]     = locked;
      status_word[BES_ERR_OVF_BIT]  = flags_reg.error_count_overflow_flag;
      status_word[BES_BIT_OVF_BIT]  = flags_reg.bit_count_overflow_flag;
      status_word[BES_ERR_SEEN_BIT] = flags_reg.bit_error_seen_flag;
      status_word[BES_SYNC_LOSS_BIT] = flags_reg.sync_loss_alarm;
      status_word[BES_ZEROS_BIT]    = flags_reg.all_zeros_alarm;
      status_word[BES_ONES_BIT]     = flags_reg.all_ones_alarm;
      status_word[BES_ERR_LOW_LSB +: 8] = err_count[7:0]; // R13
   end

   assign read_mux = (cpu_req_in.addr == BES_STATUS_ERR_LOW_OFS) ? status_word :
                     (cpu_req_in.addr == BES_ERR_HIGH_OFS)       ? err_count[23:8] : // R13
                     (cpu_req_in.addr == BES_BIT_COUNT_LOW_OFS)  ? bit_count[15:0] :
                     (cpu_req_in.addr == BES_BIT_COUNT_HIGH_OFS) ? bit_count[31:16] :
                                                                   BES_READ_IDLE;

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         rdata_reg  <= BES_READ_IDLE;
         rvalid_reg <= 1'b0;
      end else begin
         rvalid_reg <= cpu_req_in.rd;
         if (cpu_req_in.rd) rdata_reg <= read_mux;
      end
   end

   assign cpu_rdata_out  = rdata_reg;
   assign cpu_rvalid_out = rvalid_reg;

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   property p_sync_needs_run;
      @(posedge clk_in) disable iff (reset_in)
      $rose(sync_out) |-> ($past(match_cnt_reg) == BES_SYNC_MATCH_LAST);
   endproperty
   a_sync_needs_run: assert property (p_sync_needs_run) else $error("sync rose early"); // R1

   property p_sync_drop;
      @(posedge clk_in) disable iff (reset_in)
      (bit_err && win_err_reg == BES_WINDOW_ERR_LAST) |=> !sync_out;
   endproperty
   a_sync_drop: assert property (p_sync_drop) else $error("sync kept after sixth error"); // R2

   property p_err_ovf;
      @(posedge clk_in) disable iff (reset_in)
      err_sat |=> flags_reg.error_count_overflow_flag;
   endproperty
   a_err_ovf: assert property (p_err_ovf) else $error("error overflow not latched"); // R3

   property p_bit_ovf;
      @(posedge clk_in) disable iff (reset_in)
      bit_sat |=> flags_reg.bit_count_overflow_flag;
   endproperty
   a_bit_ovf: assert property (p_bit_ovf) else $error("bit overflow not latched"); // R4

   property p_irq_of;
      @(posedge clk_in) disable iff (reset_in)
      (err_sat && ctrl_in.overflow_irq_enable && master_status_irq_mask_in)
      ##1 (ctrl_in.overflow_irq_enable && master_status_irq_mask_in) |-> irq_out;
   endproperty
   a_irq_of: assert property (p_irq_of) else $error("overflow interrupt missing"); // R5

   property p_err_seen;
      @(posedge clk_in) disable iff (reset_in)
      bit_err |=> flags_reg.bit_error_seen_flag;
   endproperty
   a_err_seen: assert property (p_err_seen) else $error("bit error not latched"); // R6

   property p_loss_alarm;
      @(posedge clk_in) disable iff (reset_in)
      (state_reg == BES_SEARCH) |=> flags_reg.sync_loss_alarm;
   endproperty
   a_loss_alarm: assert property (p_loss_alarm) else $error("loss alarm not latched"); // R8

   property p_sync_irq;
      @(posedge clk_in) disable iff (reset_in)
      (sync_change && ctrl_in.sync_change_irq_enable && master_status_irq_mask_in)
      ##1 (ctrl_in.sync_change_irq_enable && master_status_irq_mask_in) |-> irq_out;
   endproperty
   a_sync_irq: assert property (p_sync_irq) else $error("sync change interrupt missing"); // R9

   property p_zeros;
      @(posedge clk_in) disable iff (reset_in)
      (bit_stb && !rx_bit && zero_run_reg == 5'd30) ##1 1'b1 |=> flags_reg.all_zeros_alarm;
   endproperty
   a_zeros: assert property (p_zeros) else $error("all-zeros alarm missing"); // R10

   property p_ones;
      @(posedge clk_in) disable iff (reset_in)
      (bit_stb && rx_bit && one_run_reg == 5'd30) ##1 1'b1 |=> flags_reg.all_ones_alarm;
   endproperty
   a_ones: assert property (p_ones) else $error("all-ones alarm missing"); // R11

   property p_read_clear;
      @(posedge clk_in) disable iff (reset_in)
      (status_read && flags_set == '0) |=> (flags_reg == '0);
   endproperty
   a_read_clear: assert property (p_read_clear) else $error("read did not clear flags"); // R12

   property p_err_count_starts;
      @(posedge clk_in) disable iff (reset_in)
      !armed_reg |-> (err_count == '0);
   endproperty
   a_err_count_starts: assert property (p_err_count_starts) else $error("counted before sync"); // R15

   property p_err_count_on;
      @(posedge clk_in) disable iff (reset_in)
      (armed_reg && !locked && bit_stb && mismatch && !count_clear && !(&err_count))
      |=> (err_count == $past(err_count) + 1'b1);
   endproperty
   a_err_count_on: assert property (p_err_count_on) else $error("count stopped off sync"); // R15

endmodule // bes_rx_status

// ==== bes_line_model.sv ====
// Purpose: Line source model that sends a reference pattern one bit at a time.
// Assumes: The send task is called at a falling clock edge.
// Notes:   The bit clock stands still low between bits.
module bes_line_model (
   input  wire logic clk_in,
   output logic      rx_clock_out,
   output logic      rx_data_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [14:0] lfsr = 15'h4A5D;
   initial begin
      rx_clock_out = 1'b0;
      rx_data_out  = 1'b0;
   end
   // Mode 0 sends the pattern, 1 all zeros, 2 all ones; flip inverts the bit.
   task automatic send(input int mode, input bit flip);
      logic nb;
      nb = lfsr[14] ^ lfsr[13];
      lfsr = {lfsr[13:0], nb};
      if (mode == 1) nb = 1'b0;
      if (mode == 2) nb = 1'b1;
      rx_data_out = nb ^ flip;
      repeat (3) @(negedge clk_in);
      rx_clock_out = 1'b1;
      repeat (3) @(negedge clk_in);
      rx_clock_out = 1'b0;
   endtask
endmodule // bes_line_model

// ==== bes_rx_status_bench.sv ====
// Purpose: Self-checking bench for the receive tester status block.
// Assumes: Counts in the bench follow every bit sent since the last clear.
// Notes:   Saturation of the counters is too long to reach here.
module bes_rx_status_bench
   import bes_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic         clk_in, reset_in, rx_clock, rx_data, mask, irq, sync, rvalid;
   bes_ctrl_t    ctrl;
   bes_cpu_req_t req;
   logic [15:0]  rdata, rd_val;
   logic [31:0]  seed = 32'hACDE, r;
   int           n_mismatch = 0, check_count = 0, bits = 0, errs = 0, b;
   bes_rx_status bes_rx_status_inst (
      .clk_in(clk_in), .reset_in(reset_in), .rx_clock_in(rx_clock),
      .rx_data_in(rx_data), .ctrl_in(ctrl), .master_status_irq_mask_in(mask),
      .cpu_req_in(req), .cpu_rdata_out(rdata), .cpu_rvalid_out(rvalid),
      .irq_out(irq), .sync_out(sync));
   bes_line_model bes_line_model_inst (
      .clk_in(clk_in), .rx_clock_out(rx_clock), .rx_data_out(rx_data));
   function automatic logic [31:0] xorshift();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic rd(input logic [7:0] a);
      req = '{rd: 1'b1, addr: a};
      @(negedge clk_in);
      req.rd = 1'b0;
      for (int i = 0; i < 4 && rvalid !== 1'b1; i++) @(negedge clk_in);
      check("rvalid", rvalid, 1'b1);
      rd_val = rdata;
      @(negedge clk_in);
   endtask
   task automatic rd_status(input logic [7:0] flags);
      rd(BES_STATUS_ERR_LOW_OFS);
      check("status", rd_val, ((errs & 255) << 8) | flags);
   endtask
   // The bench counts an errored bit only in a send with lk set; no count is compared once sync is lost.
   task automatic send(input int n, input int mode, input int lo, input int hi, input bit lk);
      for (int i = 0; i < n; i++) begin
         bes_line_model_inst.send(mode, i >= lo && i < hi);
         bits++;
         if (lk && i >= lo && i < hi) errs++;
      end
      repeat (4) @(negedge clk_in);
   endtask
   task automatic clear();
      ctrl.counter_clear_toggle = ~ctrl.counter_clear_toggle;
      repeat (3) @(negedge clk_in);
      bits = 0;
      errs = 0;
   endtask
   task automatic check_counts();
      logic [15:0] lo;
      rd(BES_BIT_COUNT_LOW_OFS);
      lo = rd_val;
      rd(BES_BIT_COUNT_HIGH_OFS);
      check("bit count", {rd_val, lo}, bits);
      rd(BES_ERR_HIGH_OFS);
      check("err high", rd_val, errs >> 8);
   endtask
   initial begin
      clk_in = 1'b0;
      forever #10 clk_in = ~clk_in;
   end
   initial begin
      #1000000;
      n_mismatch++;
      give_verdict();
   end
   initial begin
      reset_in = 1'b1;
      ctrl = '0;
      mask = 1'b0;
      req = '0;
      repeat (8) @(negedge clk_in);
      reset_in = 1'b0;
      @(negedge clk_in);
      rd_status(8'h10);
      ctrl.sync_change_irq_enable = 1'b1;
      send(60, 0, 0, 0, 0);
      check("sync", sync, 1'b1);
      check("irq masked", irq, 1'b0);
      mask = 1'b1;
      @(negedge clk_in);
      check("irq", irq, 1'b1);
      rd_status(8'h11);
      check("irq", irq, 1'b0);
      clear();
      rd_status(8'h01);
      check_counts();
      ctrl.error_irq_enable = 1'b1;
      r = xorshift();
      b = r % 20;
      send(20, 0, b, b + 1, 1);
      check("irq", irq, 1'b1);
      rd_status(8'h09);
      check_counts();
      check("irq", irq, 1'b0);
      ctrl.error_irq_enable = 1'b0;
      // Eleven errors in a row put six in one window whatever its alignment.
      send(11, 0, 0, 11, 1);
      check("sync", sync, 1'b0);
      check("irq", irq, 1'b1);
      rd(BES_STATUS_ERR_LOW_OFS);
      check("flags", rd_val[6:0], 7'h18);
      for (int m = 1; m <= 2; m++) begin
         send(31, m, 0, 0, 0);
         repeat (2) begin
            rd(BES_STATUS_ERR_LOW_OFS);
            check("run alarm", rd_val[4 + m], 1'b1);
         end
         send(1, 3 - m, 0, 0, 0);
         repeat (2) rd(BES_STATUS_ERR_LOW_OFS);
         check("run alarm", rd_val[4 + m], 1'b0);
      end
      r = xorshift();
      rd({2'b00, r[5:0]});
      check("unmapped", rd_val, BES_READ_IDLE);
      give_verdict();
   end
endmodule // bes_rx_status_bench
